// File: shared/an_pkg.sv
// constants, types and register map of the auto-negotiation resolution block
package an_pkg;
  localparam int NPROT = 15;
  // protocol slots in falling priority; slot 0 wins when several are common
  localparam int P_100G_CR4 = 0;
  localparam int P_100G_KR4 = 1;
  localparam int P_100G_KP4 = 2;
  localparam int P_100G_CR10 = 3;
  localparam int P_50G_CR2 = 4;
  localparam int P_50G_KR2 = 5;
  localparam int P_40G_CR4 = 6;
  localparam int P_40G_KR4 = 7;
  localparam int P_25G_KRCR = 8;
  localparam int P_25G_KRCR_S = 9;
  localparam int P_25G_CR1 = 10;
  localparam int P_25G_KR1 = 11;
  localparam int P_10G_KR = 12;
  localparam int P_10G_KX4 = 13;
  localparam int P_1G_KX = 14;
  // protocols on which each kind of fec may be switched on
  localparam logic [NPROT-1:0] RSFEC_OK = 15'h0F0F;
  localparam logic [NPROT-1:0] BASER_FEC_OK = 15'h1FF0;

  // link-control codes; 2'h2 is never driven
  localparam logic [1:0] LC_DISABLE = 2'h0;
  localparam logic [1:0] LC_SCAN = 2'h1;
  localparam logic [1:0] LC_ENABLE = 2'h3;

  // register offsets (byte addresses)
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_EVENT = 4'h8;
  localparam logic [3:0] OFF_MASK = 4'hC;
  // control bits
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_BYPASS = 1;
  localparam int CTRL_RESTART = 2;
  localparam int CTRL_TRAINING = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // event bits, shared by event and mask registers
  localparam int EV_BEGIN = 0;
  localparam int EV_GOOD_CHECK = 1;
  localparam int EV_DONE = 2;
  localparam int EV_FAULT = 3;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // timing
  localparam int CLK_MHZ = 20;
  localparam int TX_DISABLE_NS = 2000;
  localparam int COMPLETE_ACK_NS = 1000;
  localparam int LINK_WAIT_NS = 500000;
  localparam int TX_DISABLE_CYC = TX_DISABLE_NS * CLK_MHZ / 1000;
  localparam int COMPLETE_ACK_CYC = COMPLETE_ACK_NS * CLK_MHZ / 1000;
  localparam int LINK_WAIT_CYC = LINK_WAIT_NS * CLK_MHZ / 1000;

  typedef enum logic [2:0] {
    ST_OFF, ST_TX_DISABLE, ST_ABILITY_DETECT, ST_ACK_DETECT,
    ST_COMPLETE_ACK, ST_GOOD_CHECK, ST_GOOD, ST_BYPASS
  } an_state_t;

  // base page as exchanged with the lane framer
  typedef struct packed {
    logic [NPROT-1:0] tech;
    logic baser_cap;
    logic baser_req;
    logic rs_req;
    logic rs_cap;
    logic pause;
    logic asmdir;
    logic ack;
  } an_page_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : an_pkg

// File: rtl/an_pin_sync.sv
// three-flop input synchroniser; a change is taken once stages two and three agree
`timescale 1ns/100ps
module an_pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // asynchronous input and clean copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire logic [WIDTH-1:0] agree = ~(stage2 ^ stage3);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= (agree & stage3) | (~agree & sync_out);
    end
  end
endmodule : an_pin_sync

// File: rtl/an_resolve.sv
// auto-negotiation arbitration, advertisement and resolution outputs
//
// Overview of operation
// - each local protocol advertise bit sets its ability bit in the sent page
// - rs-fec request input is advertised to the partner
// - rs-fec capable input is advertised to the partner
// - per-protocol code: 00 disabled, 01 scan for carrier, 11 enabled; 10 never
// - base-r fec use asserts when both ends agree on it and rs-fec is not also agreed
// - rs-fec use asserts when both ends agree on it
// - transmit pause permit follows pause resolution
// - receive pause permit follows pause resolution
// - done only after negotiation ends and pcs reports receive link up
// - fault when parallel detection sees carrier on several protocols
// - one-cycle begin pulse on every entry to tx-disable, when enabled and not bypassed
// - one-cycle pulse on every entry to good-check, when enabled and not bypassed
// - with training off the good-check pulse marks mission-mode start
// - bypass stops negotiation and keeps the pcs connected
// - restart returns the machine to tx-disable from any state, when enabled and not bypassed
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/100ps
module an_resolve
  import an_pkg::*;
#(
  parameter int LINK_WAIT = LINK_WAIT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire an_pkg::reg_req_t reg_req,
  output logic [31:0] rd_data,
  output logic irq,
  // local advertisement
  input wire logic [an_pkg::NPROT-1:0] local_protocol_advertise,
  input wire logic local_rsfec_request,
  input wire logic local_rsfec_capable,
  input wire logic local_baser_fec_capable,
  input wire logic local_baser_fec_request,
  input wire logic local_pause,
  input wire logic local_asmdir,
  // lane framer, same clock
  output an_pkg::an_page_t tx_page,
  output logic tx_page_valid,
  input wire an_pkg::an_page_t rx_page,
  input wire logic rx_page_valid,
  // pcs status from the lane clock domain
  input wire logic pcs_link_up_async,
  input wire logic [an_pkg::NPROT-1:0] pd_carrier_async,
  // resolution
  output logic [an_pkg::NPROT-1:0][1:0] per_protocol_link_control,
  output logic baser_fec_use,
  output logic rsfec_use,
  output logic tx_flow_frame_permit,
  output logic rx_flow_frame_permit,
  output logic negotiation_done,
  output logic parallel_detect_error,
  output logic negotiation_begin_pulse,
  output logic good_check_entry_pulse
);
  import an_pkg::*;

  // highest-priority set bit as a one-hot mask
  function automatic logic [NPROT-1:0] pick_top(input logic [NPROT-1:0] m);
    logic [NPROT-1:0] r;
    r = '0;
    for (int i = NPROT - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : pick_top

  //////////////////////////////////////////////////////////////////////////////
  // sampled inputs
  an_page_t adv;
  an_page_t lp;
  an_state_t state;
  an_state_t next_state;
  logic [3:0] ctrl;
  logic [3:0] evt;
  logic [3:0] mask;
  logic [15:0] cnt;
  logic [NPROT-1:0] resolved;
  logic pcs_up;
  logic [NPROT-1:0] pd_carrier;

  an_pin_sync #(.WIDTH(1)) u_link_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(pcs_link_up_async),
    .sync_out(pcs_up)
  );

  an_pin_sync #(.WIDTH(NPROT)) u_pd_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(pd_carrier_async),
    .sync_out(pd_carrier)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      adv <= '0;
    end else begin
      adv.tech <= local_protocol_advertise;
      adv.rs_req <= local_rsfec_request;
      adv.rs_cap <= local_rsfec_capable;
      adv.baser_cap <= local_baser_fec_capable;
      adv.baser_req <= local_baser_fec_request;
      adv.pause <= local_pause;
      adv.asmdir <= local_asmdir;
      adv.ack <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register port
  wire logic wr_ctrl = reg_req.wr && reg_req.addr == OFF_CTRL;
  wire logic wr_mask = reg_req.wr && reg_req.addr == OFF_MASK;
  wire logic rd_event = reg_req.rd && reg_req.addr == OFF_EVENT;
  wire logic restart = wr_ctrl && reg_req.wdata[CTRL_RESTART];
  wire logic an_on = ctrl[CTRL_ENABLE] && !ctrl[CTRL_BYPASS];
  wire logic [3:0] ev_set;
  wire logic [31:0] rd_mux =
    reg_req.addr == OFF_CTRL ? {28'h0, ctrl} :
    reg_req.addr == OFF_STATUS ? {12'h0, 1'b0, resolved, 1'b0, state} :
    reg_req.addr == OFF_EVENT ? {28'h0, evt} :
    reg_req.addr == OFF_MASK ? {28'h0, mask} : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl <= CTRL_RESET;
      mask <= MASK_RESET;
      evt <= 4'h0;
      rd_data <= 32'h0;
    end else begin
      // restart bit is self-clearing
      if (wr_ctrl) ctrl <= {reg_req.wdata[CTRL_TRAINING], 1'b0, reg_req.wdata[1:0]};
      else ctrl[CTRL_RESTART] <= 1'b0;
      if (wr_mask) mask <= reg_req.wdata[3:0];
      // a new event in the clearing read cycle survives
      evt <= (rd_event ? 4'h0 : evt) | ev_set;
      rd_data <= reg_req.rd ? rd_mux : 32'h0;
    end
  end

  assign irq = |(evt & mask);

  //////////////////////////////////////////////////////////////////////////////
  // arbitration
  wire logic [NPROT-1:0] common = adv.tech & lp.tech;
  wire logic [NPROT-1:0] pd_seen = pd_carrier & adv.tech;
  wire logic pd_one = pd_seen != '0 && (pd_seen & (pd_seen - 15'h1)) == '0;
  wire logic pd_many = pd_seen != '0 && !pd_one;
  wire logic cnt_done = cnt == 16'h0;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_OFF: if (an_on) next_state = ST_TX_DISABLE;
      ST_TX_DISABLE: if (cnt_done) next_state = ST_ABILITY_DETECT;
      ST_ABILITY_DETECT: begin
        if (rx_page_valid) next_state = ST_ACK_DETECT;
        else if (pd_one) next_state = ST_GOOD_CHECK;
        else if (pd_many) next_state = ST_TX_DISABLE;
      end
      ST_ACK_DETECT: if (rx_page_valid && rx_page.ack) next_state = ST_COMPLETE_ACK;
      ST_COMPLETE_ACK: begin
        if (cnt_done) next_state = (common != '0) ? ST_GOOD_CHECK : ST_TX_DISABLE;
      end
      ST_GOOD_CHECK: begin
        if (pcs_up) next_state = ST_GOOD;
        else if (cnt_done) next_state = ST_TX_DISABLE;
      end
      ST_GOOD: if (!pcs_up) next_state = ST_TX_DISABLE;
      ST_BYPASS: next_state = ST_BYPASS;
    endcase
    if (!ctrl[CTRL_ENABLE]) next_state = ST_OFF;
    else if (ctrl[CTRL_BYPASS]) next_state = ST_BYPASS;
    else if (state == ST_BYPASS || restart) next_state = ST_TX_DISABLE;
  end

  wire logic enter = next_state != state || (restart && an_on);
  wire logic [15:0] next_cnt =
    next_state == ST_TX_DISABLE ? 16'(TX_DISABLE_CYC - 1) :
    next_state == ST_COMPLETE_ACK ? 16'(COMPLETE_ACK_CYC - 1) :
    16'(LINK_WAIT - 1);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ST_OFF;
      cnt <= 16'h0;
      lp <= '0;
      resolved <= '0;
      negotiation_begin_pulse <= 1'b0;
      good_check_entry_pulse <= 1'b0;
      parallel_detect_error <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= enter ? next_cnt : (cnt_done ? cnt : cnt - 16'h1);
      // a page from an earlier attempt must not steer a parallel-detect result
      if (enter && next_state == ST_TX_DISABLE) lp <= '0;
      else if (state == ST_ABILITY_DETECT && rx_page_valid) lp <= rx_page;
      if (enter && next_state == ST_GOOD_CHECK) begin
        resolved <= (state == ST_ABILITY_DETECT) ? pd_seen : pick_top(common);
      end else if (next_state == ST_BYPASS) begin
        resolved <= pick_top(adv.tech);
      end else if (next_state != ST_GOOD && next_state != ST_GOOD_CHECK) begin
        resolved <= '0;
      end
      // entry pulses only while negotiation is live
      negotiation_begin_pulse <= enter && next_state == ST_TX_DISABLE && an_on;
      good_check_entry_pulse <= enter && next_state == ST_GOOD_CHECK && an_on;
      if (state == ST_ABILITY_DETECT && !rx_page_valid && pd_many) parallel_detect_error <= 1'b1;
      else if (restart || !an_on || (enter && next_state == ST_GOOD_CHECK)) parallel_detect_error <= 1'b0;
    end
  end

  assign ev_set = {state == ST_ABILITY_DETECT && !rx_page_valid && pd_many,
                   next_state == ST_GOOD && state != ST_GOOD,
                   enter && next_state == ST_GOOD_CHECK && an_on,
                   enter && next_state == ST_TX_DISABLE && an_on};

  //////////////////////////////////////////////////////////////////////////////
  // transmitted page
  always_comb begin
    tx_page = adv;
    tx_page.ack = state == ST_ACK_DETECT || state == ST_COMPLETE_ACK;
  end
  assign tx_page_valid = state == ST_ABILITY_DETECT || state == ST_ACK_DETECT || state == ST_COMPLETE_ACK;

  //////////////////////////////////////////////////////////////////////////////
  // resolution outputs
  wire logic live = state == ST_GOOD_CHECK || state == ST_GOOD;
  wire logic paged = live && lp.tech != '0 && (resolved & lp.tech) != '0;
  wire logic rs_agree = adv.rs_cap && lp.rs_cap && (adv.rs_req || lp.rs_req) && (resolved & RSFEC_OK) != '0;
  wire logic br_agree = adv.baser_cap && lp.baser_cap && (adv.baser_req || lp.baser_req)
                        && (resolved & BASER_FEC_OK) != '0;
  // symmetric pause, or the one-way cases resolved by the asymmetric bits
  wire logic sym = adv.pause && lp.pause;
  wire logic tx_only = !adv.pause && adv.asmdir && lp.pause && lp.asmdir;
  wire logic rx_only = adv.pause && adv.asmdir && !lp.pause && lp.asmdir;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      per_protocol_link_control <= '0;
      rsfec_use <= 1'b0;
      baser_fec_use <= 1'b0;
      tx_flow_frame_permit <= 1'b0;
      rx_flow_frame_permit <= 1'b0;
      negotiation_done <= 1'b0;
    end else begin
      for (int i = 0; i < NPROT; i++) begin
        if (resolved[i] && (live || state == ST_BYPASS)) per_protocol_link_control[i] <= LC_ENABLE;
        else if (state == ST_ABILITY_DETECT && adv.tech[i]) per_protocol_link_control[i] <= LC_SCAN;
        else per_protocol_link_control[i] <= LC_DISABLE;
      end
      rsfec_use <= paged && rs_agree;
      baser_fec_use <= paged && !rs_agree && br_agree;
      tx_flow_frame_permit <= paged && (sym || tx_only);
      rx_flow_frame_permit <= paged && (sym || rx_only);
      negotiation_done <= state == ST_GOOD && pcs_up;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic [NPROT-1:0] code_bad;
  always_comb for (int i = 0; i < NPROT; i++) code_bad[i] = per_protocol_link_control[i] == 2'h2;
  property p_code_legal;
    @(posedge clk_sys) disable iff (!rst_b)
    code_bad == '0;
  endproperty
  a_code_legal: assert property (p_code_legal) else $error("illegal link-control code");

  logic [NPROT-1:0] en_map;
  always_comb for (int i = 0; i < NPROT; i++) en_map[i] = per_protocol_link_control[i] == LC_ENABLE;
  property p_one_enabled;
    $onehot0(en_map);
  endproperty
  a_one_enabled: assert property (p_one_enabled) else $error("several protocols enabled");

  property p_begin_pulse;
    negotiation_begin_pulse |-> state == ST_TX_DISABLE ##1 !negotiation_begin_pulse;
  endproperty
  a_begin_pulse: assert property (p_begin_pulse) else $error("begin pulse wrong");

  property p_good_pulse;
    $rose(state == ST_GOOD_CHECK) && an_on |-> good_check_entry_pulse ##1 !good_check_entry_pulse;
  endproperty
  a_good_pulse: assert property (p_good_pulse) else $error("good-check pulse missing");

  property p_done_link;
    negotiation_done |-> $past(pcs_up) && $past(state) == ST_GOOD;
  endproperty
  a_done_link: assert property (p_done_link) else $error("done without link");

  property p_restart;
    restart && an_on |=> state == ST_TX_DISABLE && negotiation_begin_pulse;
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored");

  property p_bypass;
    ctrl[CTRL_BYPASS] && ctrl[CTRL_ENABLE] |=> state == ST_BYPASS && !negotiation_begin_pulse;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not honoured");

  property p_advertise;
    $past(rst_b) |-> tx_page.tech == $past(local_protocol_advertise)
      && tx_page.rs_req == $past(local_rsfec_request) && tx_page.rs_cap == $past(local_rsfec_capable);
  endproperty
  a_advertise: assert property (p_advertise) else $error("advertisement not carried");

  property p_fec_excl;
    !(rsfec_use && baser_fec_use) && (!rsfec_use || $past(adv.rs_cap));
  endproperty
  a_fec_excl: assert property (p_fec_excl) else $error("fec resolution wrong");

  property p_fault_event;
    $rose(parallel_detect_error) |-> evt[EV_FAULT];
  endproperty
  a_fault_event: assert property (p_fault_event) else $error("fault event not recorded");

  property p_permit_live;
    (tx_flow_frame_permit || rx_flow_frame_permit || rsfec_use || baser_fec_use) |-> $past(live);
  endproperty
  a_permit_live: assert property (p_permit_live) else $error("resolution output outside link");

  property p_gc_enable;
    good_check_entry_pulse |=> $onehot(en_map);
  endproperty
  a_gc_enable: assert property (p_gc_enable) else $error("no protocol enabled in good-check");

  property p_reset_idle;
    @(posedge clk_sys) disable iff (1'b0)
    !rst_b |=> per_protocol_link_control == '0 && !negotiation_done && !irq;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs active after reset");
endmodule : an_resolve

// File: tb/an_link_partner.sv
// far-end link partner model that answers base pages on the lane
`timescale 1ns/100ps
module an_link_partner
  import an_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // scenario control
  input wire logic answer,
  input wire logic [3:0] reply_delay,
  input wire an_pkg::an_page_t my_page,
  // lane towards the block
  input wire an_pkg::an_page_t tx_page,
  input wire logic tx_page_valid,
  output an_pkg::an_page_t rx_page,
  output logic rx_page_valid
);
  logic sent_base;
  logic sent_ack;
  logic [3:0] waited;
  always @(posedge clk_sys) begin
    rx_page_valid <= 1'h0;
    // outside a page the word keeps changing, so a stale copy is never mistaken for data
    rx_page <= ~rx_page;
    if (!rst_b || !tx_page_valid) begin
      sent_base <= 1'h0;
      sent_ack <= 1'h0;
      waited <= 4'h0;
      if (!rst_b) rx_page <= '0;
    end else if (answer) begin
      if (waited != reply_delay) waited <= waited + 4'h1;
      else if (!sent_base) begin
        rx_page <= {my_page[$bits(an_page_t)-1:1], 1'h0};
        rx_page_valid <= 1'h1;
        sent_base <= 1'h1;
      end else if (!sent_ack && tx_page.ack) begin
        rx_page <= {my_page[$bits(an_page_t)-1:1], 1'h1};
        rx_page_valid <= 1'h1;
        sent_ack <= 1'h1;
      end
    end
  end
endmodule : an_link_partner

// File: tb/tb_backplane_autoneg_resolution.sv
// self-checking bench for the auto-negotiation resolution block
`timescale 1ns/100ps
module tb_backplane_autoneg_resolution;
  import an_pkg::*;
  logic clk_sys, rst_b, irq, rs_req, rs_cap, br_cap, br_req, pause, asmdir, link_up, answer;
  logic tx_page_valid, rx_page_valid, br_use, rs_use, tx_permit, rx_permit, done, pd_err;
  logic begin_p, gchk_p, last_b, last_g;
  logic [NPROT-1:0] adv, pd_carrier;
  logic [NPROT-1:0][1:0] lc;
  logic [3:0] reply_delay;
  logic [31:0] rd_data, d;
  reg_req_t reg_req;
  an_page_t tx_page, rx_page, lp_page;
  int err_total, tests_run, begins, b0;
  an_resolve #(.LINK_WAIT(50)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req), .rd_data(rd_data),
    .irq(irq), .local_protocol_advertise(adv), .local_rsfec_request(rs_req), .local_rsfec_capable(rs_cap),
    .local_baser_fec_capable(br_cap), .local_baser_fec_request(br_req), .local_pause(pause),
    .local_asmdir(asmdir), .tx_page(tx_page), .tx_page_valid(tx_page_valid), .rx_page(rx_page),
    .rx_page_valid(rx_page_valid), .pcs_link_up_async(link_up), .pd_carrier_async(pd_carrier),
    .per_protocol_link_control(lc), .baser_fec_use(br_use), .rsfec_use(rs_use),
    .tx_flow_frame_permit(tx_permit), .rx_flow_frame_permit(rx_permit), .negotiation_done(done),
    .parallel_detect_error(pd_err), .negotiation_begin_pulse(begin_p), .good_check_entry_pulse(gchk_p));
  an_link_partner partner (.clk_sys(clk_sys), .rst_b(rst_b), .answer(answer), .reply_delay(reply_delay),
    .my_page(lp_page), .tx_page(tx_page), .tx_page_valid(tx_page_valid), .rx_page(rx_page),
    .rx_page_valid(rx_page_valid));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  // begin pulses are counted, and neither pulse may last two cycles
  always @(posedge clk_sys) begin
    if (begin_p === 1'h1) begins <= begins + 1;
    if (rst_b && ((begin_p && last_b) || (gchk_p && last_g))) begin
      err_total++;
      $display("Error pulse width expected 1 seen 2");
    end
    last_b <= begin_p;
    last_g <= gchk_p;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: v, wr: 1'h1, rd: 1'h0};
    @(posedge clk_sys);
    reg_req.wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    @(posedge clk_sys);
    reg_req.rd <= 1'h0;
    #1 v = rd_data;
  endtask : rd
  function automatic logic sig(input int w);
    case (w)
      0: return begin_p;
      1: return tx_page_valid;
      2: return gchk_p;
      3: return done;
      default: return pd_err;
    endcase
  endfunction : sig
  // bounded wait on one of the block's outputs
  task automatic wait_for(input int w, input int lim);
    int n;
    n = 0;
    while (n < lim) begin
      @(posedge clk_sys);
      #1;
      if (sig(w) === 1'h1) break;
      n++;
    end
    check($sformatf("wait %0d", w), 32'(n < lim), 32'h1);
  endtask : wait_for
  function automatic logic [29:0] lc_of(input logic [NPROT-1:0] sel, input logic [1:0] code);
    for (int i = 0; i < NPROT; i++) lc_of[2*i +: 2] = sel[i] ? code : LC_DISABLE;
  endfunction : lc_of
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    check("reset lc", 32'(lc), 32'h0);
    check("reset flags", {br_use, rs_use, tx_permit, rx_permit, done, pd_err, begin_p, gchk_p}, 32'h0);
    rd(OFF_CTRL, d);
    check("ctrl", d, 32'h0);
    rd(OFF_MASK, d);
    check("mask", d, 32'h0);
    wr(4'h2, 32'hFFFFFFFF);
    rd(4'h2, d);
    check("unmapped", d, 32'h0);
    $display("reset test done");
  endtask : test_reset
  task automatic run_neg(input logic [31:0] ctrl, input logic [NPROT-1:0] ptech, input logic prs, pbr, pp, pa,
                         input int slot, input logic ers, ebr, etx, erx);
    lp_page <= '{tech: ptech, baser_cap: pbr, baser_req: pbr, rs_req: prs, rs_cap: prs, pause: pp, asmdir: pa,
                 ack: 1'h0};
    answer <= 1'h1;
    wr(OFF_CTRL, 32'h0);
    rd(OFF_EVENT, d);
    wr(OFF_MASK, 32'h4);
    wr(OFF_CTRL, ctrl);
    wait_for(0, 3);
    wait_for(1, 45);
    @(posedge clk_sys);
    #1;
    check("tech", tx_page.tech, adv);
    check("rs req", tx_page.rs_req, rs_req);
    check("rs cap", tx_page.rs_cap, rs_cap);
    check("scan", lc, lc_of(adv, LC_SCAN));
    wait_for(2, 50);
    check("early done", done, 1'h0);
    link_up <= 1'h1;
    wait_for(3, 12);
    check("lc", lc, lc_of(15'h1 << slot, LC_ENABLE));
    check("rsfec", rs_use, ers);
    check("baser", br_use, ebr);
    check("tx pause", tx_permit, etx);
    check("rx pause", rx_permit, erx);
    check("irq", irq, 1'h1);
    rd(OFF_EVENT, d);
    check("events", d, 32'h7);
    check("irq clear", irq, 1'h0);
    link_up <= 1'h0;
    $display("negotiation to slot %0d done", slot);
  endtask : run_neg
  task automatic test_fault;
    answer <= 1'h0;
    wr(OFF_CTRL, 32'h0);
    rd(OFF_EVENT, d);
    pd_carrier <= 15'h1800;
    wr(OFF_CTRL, 32'h1);
    wait_for(4, 80);
    rd(OFF_EVENT, d);
    check("fault event", d[3], 1'h1);
    wr(OFF_CTRL, 32'h5);
    pd_carrier <= 15'h1000;
    #1;
    check("restart pulse", begin_p, 1'h1);
    check("fault cleared", pd_err, 1'h0);
    wait_for(2, 80);
    @(posedge clk_sys);
    #1;
    check("pd lc", lc, lc_of(15'h1000, LC_ENABLE));
    check("pd fec", {rs_use, br_use}, 32'h0);
    pd_carrier <= 15'h0;
    $display("fault test done");
  endtask : test_fault
  task automatic test_bypass;
    wr(OFF_CTRL, 32'h3);
    repeat (3) @(posedge clk_sys);
    b0 = begins;
    repeat (60) @(posedge clk_sys);
    #1;
    check("bypass begins", 32'(begins - b0), 32'h0);
    check("bypass lc", lc, lc_of(15'h0800, LC_ENABLE));
    rd(OFF_STATUS, d);
    check("bypass state", d[2:0], 32'h7);
    wr(OFF_CTRL, 32'h0);
    $display("bypass test done");
  endtask : test_bypass
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'h0;
    reg_req = '0;
    adv = 15'h5800;
    pd_carrier = 15'h0;
    {rs_req, rs_cap, br_cap, br_req, pause, asmdir, link_up, answer} = 8'hF8;
    reply_delay = 4'h0;
    lp_page = '0;
    err_total = 0;
    tests_run = 0;
    begins = 0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    #1;
    test_reset;
    run_neg(32'h1, 15'h1800, 1'h1, 1'h1, 1'h1, 1'h0, 11, 1'h1, 1'h0, 1'h1, 1'h1);
    asmdir <= 1'h1;
    reply_delay <= 4'h9;
    run_neg(32'h9, 15'h1000, 1'h0, 1'h1, 1'h0, 1'h1, 12, 1'h0, 1'h1, 1'h0, 1'h1);
    test_fault;
    test_bypass;
    complete_run;
  end
  initial begin
    #200000;
    err_total++;
    $display("Error watchdog expected finish seen hang");
    complete_run;
  end
endmodule : tb_backplane_autoneg_resolution
